// ==== hw/ssrb_change_flags.sv ====
// Sticky change-flag register cleared by a read, set winning over clear
`default_nettype none

module ssrb_change_flags #(
    parameter int W = 16,
    parameter logic [W-1:0] USED_MASK = '1
) (
    ssrb_flag_if.owner fl
);
    logic [W-1:0] flags;
    logic [W-1:0] next_flags;

    // Clear on read first, then new events on top so none is lost
    always_comb begin
        next_flags = fl.rd_clr ? '0 : flags;
        next_flags = (next_flags | fl.evt) & USED_MASK;
    end

    // Flag storage
    always_ff @(posedge fl.clk) begin
        if (!fl.rst_n) begin
            flags <= '0;
        end else begin
            flags <= next_flags;
        end
    end

    assign fl.flags = flags;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    chk_event_kept_on_clear: assert property (@(posedge fl.clk) disable iff (!fl.rst_n)
        (fl.rd_clr && (fl.evt & USED_MASK) != '0) |=> (flags & $past(fl.evt & USED_MASK)) == $past(fl.evt & USED_MASK))
        else $error("change event lost during clearing read");

    chk_flag_sticky_set: assert property (@(posedge fl.clk) disable iff (!fl.rst_n)
        (!fl.rd_clr && (fl.evt & USED_MASK) != '0) ##1 (!fl.rd_clr && fl.evt == '0) |=>
        (flags & $past(fl.evt & USED_MASK, 2)) == $past(fl.evt & USED_MASK, 2))
        else $error("change flag did not stay set until read");

    chk_read_zeroes_flags: assert property (@(posedge fl.clk) disable iff (!fl.rst_n)
        (fl.rd_clr && fl.evt == '0) |=> flags == '0)
        else $error("change flags not zeroed after read");
endmodule

`default_nettype wire

// ==== hw/ssrb_flag_if.sv ====
// Interface between the bank and one clear-on-read change-flag register
`default_nettype none

interface ssrb_flag_if #(
    parameter int W = 16
) (
    input wire logic clk,
    input wire logic rst_n
);
    logic [W-1:0] evt;
    logic rd_clr;
    logic [W-1:0] flags;

    modport owner(input clk, input rst_n, input evt, input rd_clr, output flags);
    modport user(output evt, output rd_clr, input flags);
endinterface

`default_nettype wire

// ==== hw/ssrb_pkg.sv ====
// Constants, register map and types of the system status register bank
//
// Operation
// - Holding-register addresses decode zero-based
// - Status-change register clears after each read
// - Status-change bits 15-11 always read one
// - Status-change bits 10-0 name status groups
// - Group bit sets when group register changes
// - Config-change register at one, cleared by read
// - Config-change bits map config groups, 2 and 13 reserved
// - Discrete I/O upper byte reports inputs
// - Discrete I/O lower byte reports outputs
// - Annunciator register valid only when enabled
// - Annunciator bits 7-0 report inputs 8-1
// - Limits bits 15-12 reserved, read zero
// - Limits bits 11-0 report limit trips
// - Module state bits 10, 9 report stored blocks
// - Read function serves 1 to 125 registers
`default_nettype none

package ssrb_pkg;

    // ----------------------------------------------------------------
    // Widths
    // ----------------------------------------------------------------
    localparam int REG_W = 16;
    localparam int ADDR_W = 16;
    localparam int CNT_W = 16;
    localparam int CODE_W = 8;
    localparam int ST_FLAG_W = 11;
    localparam int CFG_FLAG_W = 16;
    localparam int ANN_W = 8;
    localparam int LIM_W = 12;
    localparam int DIO_W = 16;

    // ----------------------------------------------------------------
    // Register map, zero-based holding-register addresses
    // ----------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_STATUS_CHG = 16'h0000;
    localparam logic [ADDR_W-1:0] ADDR_CONFIG_CHG = 16'h0001;
    localparam logic [ADDR_W-1:0] ADDR_DISCRETE_IO = 16'h0002;
    localparam logic [ADDR_W-1:0] ADDR_ANNUN = 16'h0003;
    localparam logic [ADDR_W-1:0] ADDR_LIMITS = 16'h0004;
    localparam logic [ADDR_W-1:0] ADDR_PLUGIN_STATE = 16'h0005;
    localparam logic [ADDR_W-1:0] ADDR_LAST = ADDR_PLUGIN_STATE;
    localparam logic [ADDR_W-1:0] ADDR_STEP = 16'h0001;

    // ----------------------------------------------------------------
    // Field layouts and fixed bits
    // ----------------------------------------------------------------
    localparam logic [REG_W-ST_FLAG_W-1:0] ST_RESERVED_ONES = 5'h1f;
    localparam logic [ST_FLAG_W-1:0] ST_USED_MASK = 11'h7ff;
    localparam int ST_ACTIVE_LOCKOUT = 0;
    localparam int ST_ALERT_LOG = 10;
    localparam logic [CFG_FLAG_W-1:0] CFG_USED_MASK = 16'hdffb;
    localparam int CFG_SYSTEM = 0;
    localparam int CFG_PARAM_BLOCK = 15;
    localparam int PLUGIN_ALERT_BIT = 10;
    localparam int PLUGIN_RANGE_BIT = 9;

    // ----------------------------------------------------------------
    // Protocol function and exception codes
    // ----------------------------------------------------------------
    localparam logic [CODE_W-1:0] FUNC_READ_HOLD = 8'h03;
    localparam logic [CODE_W-1:0] FUNC_WRITE_SINGLE = 8'h06;
    localparam logic [CODE_W-1:0] FUNC_WRITE_MULTI = 8'h10;
    localparam logic [CODE_W-1:0] EXC_BAD_FUNC = 8'h01;
    localparam logic [CODE_W-1:0] EXC_BAD_ADDR = 8'h02;
    localparam logic [CODE_W-1:0] EXC_BAD_COUNT = 8'h03;
    localparam logic [CNT_W-1:0] MAX_READ_REGS = 16'h007d;
    localparam logic [CNT_W-1:0] ZERO_COUNT = 16'h0000;
    localparam logic [CNT_W-1:0] COUNT_STEP = 16'h0001;

    // ----------------------------------------------------------------
    // Request sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        SSRB_IDLE = 3'b001,
        SSRB_READ = 3'b010,
        SSRB_EXC = 3'b100
    } ssrb_state_t;

endpackage

`default_nettype wire

// ==== hw/ssrb_top.sv ====
// System status register bank: holding-register reads of addresses 0 to 5
`default_nettype none

module ssrb_top (
    input wire logic sys_clk,
    input wire logic rst_n,
    // Holding-register request
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [ssrb_pkg::CODE_W-1:0] req_func,
    input wire logic [ssrb_pkg::ADDR_W-1:0] req_addr,
    input wire logic [ssrb_pkg::CNT_W-1:0] req_count,
    // Answer, one word a cycle or one exception
    output logic rsp_valid,
    output logic [ssrb_pkg::REG_W-1:0] rsp_data,
    output logic rsp_last,
    output logic rsp_exc,
    output logic [ssrb_pkg::CODE_W-1:0] rsp_exc_code,
    // Group change events from the rest of the controller
    input wire logic [ssrb_pkg::ST_FLAG_W-1:0] st_evt,
    input wire logic [ssrb_pkg::CFG_FLAG_W-1:0] cfg_evt,
    // Live status inputs
    input wire logic [ssrb_pkg::DIO_W-1:0] dio_in,
    input wire logic annun_enable,
    input wire logic [ssrb_pkg::ANN_W-1:0] annun_in,
    input wire logic [ssrb_pkg::LIM_W-1:0] limit_in,
    input wire logic plugin_alert_stored,
    input wire logic plugin_range_stored
);
    import ssrb_pkg::*;

    // ----------------------------------------------------------------
    // Change-flag registers
    // ----------------------------------------------------------------
    ssrb_state_t state;
    ssrb_state_t next_state;
    logic [ADDR_W-1:0] cur_addr;
    logic [ADDR_W-1:0] next_cur_addr;

    ssrb_flag_if #(.W(ST_FLAG_W)) st_if (.clk(sys_clk), .rst_n(rst_n));
    ssrb_flag_if #(.W(CFG_FLAG_W)) cfg_if (.clk(sys_clk), .rst_n(rst_n));

    ssrb_change_flags #(.W(ST_FLAG_W), .USED_MASK(ST_USED_MASK)) u_status_chg (
        .fl(st_if.owner)
    );

    ssrb_change_flags #(.W(CFG_FLAG_W), .USED_MASK(CFG_USED_MASK)) u_config_chg (
        .fl(cfg_if.owner)
    );

    // Events in, clearing strobe when the word is emitted
    assign st_if.evt = st_evt;
    assign cfg_if.evt = cfg_evt;
    assign st_if.rd_clr = (state == SSRB_READ) && (cur_addr == ADDR_STATUS_CHG);
    assign cfg_if.rd_clr = (state == SSRB_READ) && (cur_addr == ADDR_CONFIG_CHG);

    // ----------------------------------------------------------------
    // Input snapshots
    // ----------------------------------------------------------------
    logic [DIO_W-1:0] dio_q;
    logic [DIO_W-1:0] next_dio_q;
    logic annun_en_q;
    logic next_annun_en_q;
    logic [ANN_W-1:0] annun_q;
    logic [ANN_W-1:0] next_annun_q;
    logic [LIM_W-1:0] limit_q;
    logic [LIM_W-1:0] next_limit_q;
    logic plugin_alert_q;
    logic next_plugin_alert_q;
    logic plugin_range_q;
    logic next_plugin_range_q;

    // Sample live inputs every cycle
    always_comb begin
        next_dio_q = dio_in;
        next_annun_en_q = annun_enable;
        next_annun_q = annun_in;
        next_limit_q = limit_in;
        next_plugin_alert_q = plugin_alert_stored;
        next_plugin_range_q = plugin_range_stored;
    end

    // Snapshot storage
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            dio_q <= '0;
            annun_en_q <= 1'b0;
            annun_q <= '0;
            limit_q <= '0;
            plugin_alert_q <= 1'b0;
            plugin_range_q <= 1'b0;
        end else begin
            dio_q <= next_dio_q;
            annun_en_q <= next_annun_en_q;
            annun_q <= next_annun_q;
            limit_q <= next_limit_q;
            plugin_alert_q <= next_plugin_alert_q;
            plugin_range_q <= next_plugin_range_q;
        end
    end

    // ----------------------------------------------------------------
    // Address decode and word assembly
    // ----------------------------------------------------------------
    logic [CNT_W-1:0] remaining;
    logic [CNT_W-1:0] next_remaining;
    logic [CODE_W-1:0] exc_code;
    logic [CODE_W-1:0] next_exc_code;
    logic [ADDR_W:0] end_addr;
    logic [REG_W-1:0] read_word;

    // True when an address lies inside this bank
    function automatic logic in_map(input logic [ADDR_W:0] a);
        return a <= {1'b0, ADDR_LAST};
    endfunction

    assign end_addr = {1'b0, req_addr} + {1'b0, req_count} - {1'b0, COUNT_STEP};

    // Word at the current address, zero-based
    always_comb begin
        read_word = '0;
        case (cur_addr)
            ADDR_STATUS_CHG: begin
                read_word = {ST_RESERVED_ONES, st_if.flags};
            end
            ADDR_CONFIG_CHG: begin
                read_word = cfg_if.flags;
            end
            ADDR_DISCRETE_IO: begin
                read_word = dio_q;
            end
            ADDR_ANNUN: begin
                if (annun_en_q) begin
                    read_word = {{(REG_W-ANN_W){1'b0}}, annun_q};
                end
            end
            ADDR_LIMITS: begin
                read_word = {{(REG_W-LIM_W){1'b0}}, limit_q};
            end
            ADDR_PLUGIN_STATE: begin
                read_word[PLUGIN_ALERT_BIT] = plugin_alert_q;
                read_word[PLUGIN_RANGE_BIT] = plugin_range_q;
            end
            default: begin
                read_word = '0;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Request sequencer
    // ----------------------------------------------------------------
    assign req_ready = (state == SSRB_IDLE);

    // Validate a request, then walk the addresses one word a cycle
    always_comb begin
        next_state = state;
        next_cur_addr = cur_addr;
        next_remaining = remaining;
        next_exc_code = exc_code;
        case (state)
            SSRB_IDLE: begin
                if (req_valid) begin
                    next_cur_addr = req_addr;
                    next_remaining = req_count;
                    next_state = SSRB_EXC;
                    if (req_func == FUNC_READ_HOLD) begin
                        if (req_count == ZERO_COUNT || req_count > MAX_READ_REGS) begin
                            next_exc_code = EXC_BAD_COUNT;
                        end else if (!in_map({1'b0, req_addr}) || !in_map(end_addr)) begin
                            next_exc_code = EXC_BAD_ADDR;
                        end else begin
                            next_state = SSRB_READ;
                        end
                    end else if (req_func == FUNC_WRITE_SINGLE || req_func == FUNC_WRITE_MULTI) begin
                        next_exc_code = EXC_BAD_ADDR;
                    end else begin
                        next_exc_code = EXC_BAD_FUNC;
                    end
                end
            end
            SSRB_READ: begin
                next_cur_addr = cur_addr + ADDR_STEP;
                next_remaining = remaining - COUNT_STEP;
                if (remaining == COUNT_STEP) begin
                    next_state = SSRB_IDLE;
                end
            end
            SSRB_EXC: begin
                next_state = SSRB_IDLE;
            end
            default: begin
                next_state = SSRB_IDLE;
            end
        endcase
    end

    // Sequencer storage
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state <= SSRB_IDLE;
            cur_addr <= '0;
            remaining <= '0;
            exc_code <= '0;
        end else begin
            state <= next_state;
            cur_addr <= next_cur_addr;
            remaining <= next_remaining;
            exc_code <= next_exc_code;
        end
    end

    // ----------------------------------------------------------------
    // Answer registers
    // ----------------------------------------------------------------
    logic next_rsp_valid;
    logic [REG_W-1:0] next_rsp_data;
    logic next_rsp_last;
    logic next_rsp_exc;
    logic [CODE_W-1:0] next_rsp_exc_code;

    // Data and exception code hold their last value between answers
    always_comb begin
        next_rsp_valid = (state == SSRB_READ);
        next_rsp_last = (state == SSRB_READ) && (remaining == COUNT_STEP);
        next_rsp_data = (state == SSRB_READ) ? read_word : rsp_data;
        next_rsp_exc = (state == SSRB_EXC);
        next_rsp_exc_code = (state == SSRB_EXC) ? exc_code : rsp_exc_code;
    end

    // Answer storage
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rsp_valid <= 1'b0;
            rsp_data <= '0;
            rsp_last <= 1'b0;
            rsp_exc <= 1'b0;
            rsp_exc_code <= '0;
        end else begin
            rsp_valid <= next_rsp_valid;
            rsp_data <= next_rsp_data;
            rsp_last <= next_rsp_last;
            rsp_exc <= next_rsp_exc;
            rsp_exc_code <= next_rsp_exc_code;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    logic [ADDR_W-1:0] rsp_addr_h;
    logic req_take;

    // Address of the word now on the answer port
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rsp_addr_h <= '0;
        end else begin
            rsp_addr_h <= cur_addr;
        end
    end

    assign req_take = req_valid && req_ready;

    chk_status_word_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (rsp_valid && rsp_addr_h == ADDR_STATUS_CHG) |-> rsp_data == {ST_RESERVED_ONES, $past(st_if.flags)})
        else $error("status-change word wrong at address zero");

    chk_status_read_clears: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state == SSRB_READ && cur_addr == ADDR_STATUS_CHG && st_evt == '0) |=> st_if.flags == '0)
        else $error("status-change flags survive a read");

    chk_config_read_clears: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state == SSRB_READ && cur_addr == ADDR_CONFIG_CHG && cfg_evt == '0) |=> cfg_if.flags == '0)
        else $error("config-change flags survive a read");

    chk_config_reserved: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (rsp_valid && rsp_addr_h == ADDR_CONFIG_CHG) |-> (rsp_data & ~CFG_USED_MASK) == '0)
        else $error("config-change reserved bit set");

    chk_discrete_io: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (rsp_valid && rsp_addr_h == ADDR_DISCRETE_IO) |-> rsp_data == $past(dio_in, 2))
        else $error("discrete I/O word does not follow inputs");

    chk_annun_gated: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (rsp_valid && rsp_addr_h == ADDR_ANNUN) |->
        rsp_data == ($past(annun_enable, 2) ? {{(REG_W-ANN_W){1'b0}}, $past(annun_in, 2)} : '0))
        else $error("annunciator word wrong");

    chk_limits_word: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (rsp_valid && rsp_addr_h == ADDR_LIMITS) |-> rsp_data == {{(REG_W-LIM_W){1'b0}}, $past(limit_in, 2)})
        else $error("limits word wrong");

    chk_module_state: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (rsp_valid && rsp_addr_h == ADDR_PLUGIN_STATE) |->
        rsp_data[PLUGIN_ALERT_BIT] == $past(plugin_alert_stored, 2) &&
        rsp_data[PLUGIN_RANGE_BIT] == $past(plugin_range_stored, 2))
        else $error("module state word wrong");

    chk_write_refused: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (req_take && (req_func == FUNC_WRITE_SINGLE || req_func == FUNC_WRITE_MULTI)) |=>
        ##1 (rsp_exc && rsp_exc_code == EXC_BAD_ADDR && !rsp_valid))
        else $error("write not refused with exception");

    chk_count_limit: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (req_take && req_func == FUNC_READ_HOLD && req_count > MAX_READ_REGS) |=>
        ##1 (rsp_exc && rsp_exc_code == EXC_BAD_COUNT))
        else $error("oversized read not refused");

    chk_single_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (req_take && req_func == FUNC_READ_HOLD && req_count == COUNT_STEP && req_addr <= ADDR_LAST) |=>
        ##1 (rsp_valid && rsp_last) ##1 !rsp_valid)
        else $error("single-register read not answered by one word");

    cov_status_read: cover property (@(posedge sys_clk) disable iff (!rst_n)
        rsp_valid && rsp_addr_h == ADDR_STATUS_CHG && rsp_data[ST_ALERT_LOG]);

    cov_full_map_read: cover property (@(posedge sys_clk) disable iff (!rst_n)
        rsp_valid && rsp_last && rsp_addr_h == ADDR_LAST && $past(rsp_valid, 5));

    cov_write_exception: cover property (@(posedge sys_clk) disable iff (!rst_n)
        rsp_exc && rsp_exc_code == EXC_BAD_ADDR);

    cov_clear_with_event: cover property (@(posedge sys_clk) disable iff (!rst_n)
        cfg_if.rd_clr && cfg_evt[CFG_PARAM_BLOCK]);
endmodule

`default_nettype wire

// ==== sim/ssrb_master.sv ====
// Serial bus master model that polls the holding registers
`default_nettype none

module ssrb_master
    import ssrb_pkg::*;
(
    input wire logic sys_clk,
    input wire logic req_ready,
    output logic req_valid,
    output logic [ssrb_pkg::CODE_W-1:0] req_func,
    output logic [ssrb_pkg::ADDR_W-1:0] req_addr,
    output logic [ssrb_pkg::CNT_W-1:0] req_count
);
    timeunit 1ns;
    timeprecision 100ps;

    // Idle bus at time zero
    initial begin
        req_valid = 1'b0;
        req_func = 8'h00;
        req_addr = 16'h0000;
        req_count = 16'h0000;
    end

    // Present one request after a gap and hold it until it is taken
    task automatic issue(input logic [7:0] f, input logic [15:0] a, input logic [15:0] c, input int gap);
        int n;
        n = 0;
        repeat (gap) @(posedge sys_clk);
        @(posedge sys_clk);
        req_valid <= 1'b1;
        req_func <= f;
        req_addr <= a; // Zero-based, no 40001 offset
        req_count <= c;
        @(posedge sys_clk);
        while (req_ready !== 1'b1 && n < 200) begin
            n++;
            @(posedge sys_clk);
        end
        req_valid <= 1'b0;
        req_func <= ~f; // Released lines carry no stale value
        req_addr <= ~a;
        req_count <= ~c;
    endtask
endmodule

`default_nettype wire

// ==== sim/ssrb_top_test.sv ====
// Self-checking testbench of the system status register bank
`default_nettype none

module ssrb_top_test;
    timeunit 1ns;
    timeprecision 100ps;
    import ssrb_pkg::*;

    typedef struct packed {logic exc; logic last; logic [15:0] data;} ssrb_exp_t;
    logic sys_clk, rst_n, req_valid, req_ready, rsp_valid, rsp_last, rsp_exc;
    logic annun_enable, plugin_alert_stored, plugin_range_stored;
    logic [7:0] req_func, rsp_exc_code, annun_in;
    logic [15:0] req_addr, req_count, rsp_data, cfg_evt, dio_in, a, c;
    logic [10:0] st_evt;
    logic [11:0] limit_in;
    ssrb_exp_t exp_q[$];
    ssrb_exp_t m_e;
    int miscompares = 0;
    int checks = 0;
    int i;
    logic [7:0] tf[7] = '{FUNC_READ_HOLD, FUNC_READ_HOLD, FUNC_READ_HOLD, FUNC_READ_HOLD,
                          FUNC_WRITE_SINGLE, FUNC_WRITE_MULTI, 8'h11};
    logic [15:0] ta[7] = '{16'h0000, 16'h0000, 16'h0000, 16'h0005, 16'h0002, 16'h0000, 16'h0000};
    logic [15:0] tc[7] = '{16'h0000, 16'h007e, 16'h007d, 16'h0002, 16'h0001, 16'h0001, 16'h0001};
    logic [7:0] tx[7] = '{8'h03, 8'h03, 8'h02, 8'h02, 8'h02, 8'h02, 8'h01};

    ssrb_top ssrb_top_inst (.sys_clk(sys_clk), .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready),
        .req_func(req_func), .req_addr(req_addr), .req_count(req_count), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .rsp_last(rsp_last), .rsp_exc(rsp_exc), .rsp_exc_code(rsp_exc_code),
        .st_evt(st_evt), .cfg_evt(cfg_evt), .dio_in(dio_in), .annun_enable(annun_enable),
        .annun_in(annun_in), .limit_in(limit_in), .plugin_alert_stored(plugin_alert_stored),
        .plugin_range_stored(plugin_range_stored));
    ssrb_master ssrb_master_inst (.sys_clk(sys_clk), .req_ready(req_ready), .req_valid(req_valid),
        .req_func(req_func), .req_addr(req_addr), .req_count(req_count));

    // Clock, 50 ns period
    initial sys_clk = 1'b0;
    always #25 sys_clk = ~sys_clk;

    // ------------------------------------------------------------
    // Compare and report
    // ------------------------------------------------------------
    task automatic cmp_word(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic cmp_flag(input string nm, input logic e, input logic g);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic final_report();
        if (exp_q.size() != 0) miscompares++;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // Expected live word of addresses 2 to 5
    function automatic logic [15:0] snap(input logic [15:0] ad);
        case (ad)
            ADDR_DISCRETE_IO: return dio_in;
            ADDR_ANNUN: return annun_enable ? {8'h00, annun_in} : 16'h0000;
            ADDR_LIMITS: return {4'h0, limit_in};
            default: return {5'h00, plugin_alert_stored, plugin_range_stored, 9'h000};
        endcase
    endfunction

    // ------------------------------------------------------------
    // Request tasks, each noting its expected answers first
    // ------------------------------------------------------------
    task automatic drain();
        int n;
        n = 0;
        while (exp_q.size() != 0 && n < 300) begin
            n++;
            @(posedge sys_clk);
        end
        @(posedge sys_clk);
    endtask

    task automatic rd(input logic [15:0] ad, input logic [15:0] cn, input logic [15:0] sx, input logic [15:0] cx);
        logic [15:0] k;
        for (k = 16'h0000; k < cn; k++) begin
            exp_q.push_back('{1'b0, k == cn - 16'h0001,
                (ad + k == 16'h0000) ? sx : (ad + k == 16'h0001) ? cx : snap(ad + k)});
        end
        ssrb_master_inst.issue(FUNC_READ_HOLD, ad, cn, $urandom_range(0, 3));
        drain();
    endtask

    task automatic ex(input logic [7:0] f, input logic [15:0] ad, input logic [15:0] cn, input logic [7:0] cd);
        exp_q.push_back('{1'b1, 1'b0, {8'h00, cd}});
        ssrb_master_inst.issue(f, ad, cn, 0);
        drain();
    endtask

    // Answer watcher: oldest note against each answer
    always @(posedge sys_clk) begin
        if (rst_n === 1'b1 && (rsp_valid === 1'b1 || rsp_exc === 1'b1)) begin
            if (exp_q.size() == 0) begin
                miscompares++;
                $display("[ERR] answer expected none seen %h", rsp_data);
            end else begin
                m_e = exp_q.pop_front();
                cmp_flag("rsp_exc", m_e.exc, rsp_exc);
                if (m_e.exc) cmp_word("rsp_exc_code", m_e.data, {8'h00, rsp_exc_code});
                else cmp_word("rsp_data", m_e.data, rsp_data);
                if (!m_e.exc) cmp_flag("rsp_last", m_e.last, rsp_last);
                cmp_flag("req_ready", m_e.exc | m_e.last, req_ready);
            end
        end
    end

    // Watchdog against a hang
    initial begin
        #(50 * 20000);
        miscompares++;
        $display("watchdog expired");
        final_report();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        st_evt = 11'h000;
        cfg_evt = 16'h0000;
        annun_enable = 1'b1;
        void'($urandom(45116));
        {dio_in, annun_in, limit_in, plugin_alert_stored, plugin_range_stored} = 38'({$urandom, $urandom});
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd(16'h0000, 16'h0006, 16'hf800, 16'h0000);
        $display("test map done");
        @(posedge sys_clk);
        st_evt <= 11'h7ff;
        cfg_evt <= 16'hffff;
        @(posedge sys_clk);
        st_evt <= 11'h000;
        cfg_evt <= 16'h0000;
        rd(16'h0000, 16'h0002, 16'hffff, 16'hdffb);
        rd(16'h0000, 16'h0002, 16'hf800, 16'h0000);
        $display("test group events done");
        @(posedge sys_clk);
        st_evt <= 11'h401;
        cfg_evt <= 16'h8001;
        rd(16'h0000, 16'h0002, 16'hfc01, 16'h8001);
        st_evt <= 11'h000;
        cfg_evt <= 16'h0000;
        rd(16'h0000, 16'h0002, 16'hfc01, 16'h8001);
        rd(16'h0000, 16'h0002, 16'hf800, 16'h0000);
        $display("test event at clear done");
        for (i = 0; i < 7; i++) ex(tf[i], ta[i], tc[i], tx[i]);
        rd(16'h0002, 16'h0004, 16'h0000, 16'h0000);
        $display("test refusals done");
        for (i = 0; i < 12; i++) begin
            {dio_in, annun_in, limit_in, plugin_alert_stored, plugin_range_stored} <= 38'({$urandom, $urandom});
            annun_enable <= (i % 3) != 0;
            @(posedge sys_clk);
            a = 16'h0002 + 16'($urandom_range(0, 3));
            c = 16'h0001 + 16'($urandom_range(0, 5 - a));
            rd(a, c, 16'h0000, 16'h0000);
        end
        $display("test random snapshots done");
        final_report();
    end
endmodule

`default_nettype wire
